// file: bench/scc_ctrl_model.sv
/*
  Motion controller model: sends framed command words on the serial
  link and collects the status word shifted back.
  Assumes the core samples SCK with its own clock; SCK period 200 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_ctrl_model (
  output logic      o_sck,
  output logic      o_sdi,
  output logic      o_cs_n,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  logic last_q;  // Last data bit driven

  // Idle link: clock low, chip select high
  initial begin
    o_sck  = 1'b0;
    o_sdi  = 1'b1;
    o_cs_n = 1'b1;
    last_q = 1'b0;
  end

  // One word per microstep nbits other than 12 gives a broken frame
  task automatic frame(input logic [11:0] cmd, input int nbits, output logic [11:0] st);
    int i;
    st = 12'h000;
    o_cs_n = 1'b0;
    #200;
    for (i = 0; i < nbits; i++) begin
      o_sdi = (i < 12) ? cmd[11-i] : 1'b0;  // MSB first
      last_q = o_sdi;
      #100 o_sck = 1'b1;
      // Status sampled late in the high phase, where it has settled
      #100 st = {st[10:0], i_sdo & i_sdo_oe};
      o_sck = 1'b0;
    end
    #100 o_cs_n = 1'b1;
    o_sdi = ~last_q;  // Released line must not show a stale bit
    #200;
  endtask
endmodule
`default_nettype wire

// file: bench/test_stepper_spi_coil_control.sv
/*
  Self-checking bench for the coil control core: words, status, faults,
  open load, standby and shutdown.
  Assumes the serial partner model and the core's hand-over timing.
*/
`timescale 1ns/1ps
`default_nettype none
module test_stepper_spi_coil_control;
  import scc_pkg::*;
  logic        clk, rst, active_low_enable, ser, analog_ref_select_n, vlow, ot, pw, uv, low_side_overcurrent_a, offb, osc, fs, pwm;
  logic [2:0]  load;    // Load value fed to the core
  logic        sck, sdi, cs_n, sdo, sdo_oe;
  logic [3:0]  ca, cb;  // Applied current codes
  logic        mixed_decay_a, mixed_decay_b, bridge_a_polarity, bridge_b_polarity, a1, a2, b1, b2, pwr, osc_en, ref_on, ext_ref;
  logic [11:0] st;      // Status from the last frame
  int          n_fail, checks;

  // Core clock, 25 ns
  always #12.5 clk = ~clk;

  scc_core scc_core_i (.I_CLK(clk), .I_SYS_RST(rst), .I_SPI_SCK(sck), .I_SPI_SDI(sdi),
    .I_SPI_CS_N(cs_n), .I_ACTIVE_LOW_ENABLE_N(active_low_enable), .I_SERIAL_MODE_SELECT(ser),
    .I_ANALOG_REF_SELECT_N(analog_ref_select_n), .I_LOGIC_SUPPLY_LOW(vlow), .I_OVERTEMP(ot),
    .I_TEMP_PREWARN(pw), .I_SUPPLY_LOW(uv), .I_OC_LOW_A(low_side_overcurrent_a), .I_OC_LOW_B(1'b0),
    .I_OC_HIGH(1'b0), .I_PWM_TICK(pwm), .I_PWM_OFF_A(1'b0), .I_PWM_OFF_B(offb),
    .I_OSC_TICK(osc), .I_FULLSTEP(fs), .I_LOAD_INDICATOR(load), .O_SPI_SDO(sdo),
    .O_SPI_SDO_OE(sdo_oe), .O_COIL_A_CURRENT_CODE(ca), .O_COIL_B_CURRENT_CODE(cb),
    .O_MIXED_DECAY_A(mixed_decay_a), .O_MIXED_DECAY_B(mixed_decay_b), .O_BRIDGE_A_POLARITY(bridge_a_polarity),
    .O_BRIDGE_B_POLARITY(bridge_b_polarity), .O_COIL_A_OUT_1(a1), .O_COIL_A_OUT_2(a2),
    .O_COIL_B_OUT_1(b1), .O_COIL_B_OUT_2(b2), .O_POWER_EN(pwr), .O_OSC_EN(osc_en),
    .O_REF_ON(ref_on), .O_EXT_REF(ext_ref));

  scc_ctrl_model scc_ctrl_model_i (.o_sck(sck), .o_sdi(sdi), .o_cs_n(cs_n),
    .i_sdo(sdo), .i_sdo_oe(sdo_oe));

  // Single compare for every result kind, widened to a word
  task chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Applied command fields, packed back into word order
  function automatic logic [11:0] outs();
    return {mixed_decay_a, ca, bridge_a_polarity, mixed_decay_b, cb, bridge_b_polarity};
  endfunction

  task wclk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Event pulses held long enough for the synchroniser
  task automatic pulse(ref logic s, input int n);
    repeat (n) begin
      s = 1'b1;
      wclk(4);
      s = 1'b0;
      wclk(4);
    end
  endtask

  task xfer(input logic [11:0] cmd, input int nb);
    scc_ctrl_model_i.frame(cmd, nb, st);
    wclk(4);
  endtask

  // Word fields, polarity and status framing
  task t_cmd;
    chk(outs(), 12'h000, "cmd after reset");
    load = 3'h5;
    pulse(fs, 1);
    xfer(12'hD0B, 12);
    chk(st, 12'hB00, "status idle");
    chk(outs(), 12'hD0B, "fields");
    chk({a1, a2, b1, b2, pwr, osc_en}, 12'h027, "bridges");
    xfer(12'h3FF, 11);
    xfer(12'h3FF, 13);
    chk(outs(), 12'hD0B, "short/long frame");
    // Standstill: both codes roughly halved
    xfer(12'hA85, 12);
    chk(outs(), 12'hA85, "standstill current");
  endtask

  // Live fault bits; overtemp cuts the stage
  task t_fault;
    {ot, pw, uv} = 3'b111;
    wclk(8);
    chk(pwr, 12'h000, "overtemp power");
    xfer(12'hD0B, 12);
    chk(st, 12'hBEC, "fault status");
    {ot, pw, uv} = 3'b000;
    wclk(8);
  endtask

  // Three overcurrent events, then the all-zero word
  task t_oc;
    pulse(low_side_overcurrent_a, 3);
    xfer(12'hD0B, 12);
    chk(st, 12'hB0D, "oc trip");
    chk({a1, a2, b1, b2}, 12'h001, "oc hold");
    // Bridge A stays off until the 63rd PWM cycle has passed
    pulse(pwm, 62);
    chk({a1, a2, b1, b2}, 12'h001, "oc hold 62");
    pulse(pwm, 1);
    chk({a1, a2, b1, b2}, 12'h009, "oc hold end");
    xfer(12'h000, 12);
    chk({pwr, osc_en}, 12'h000, "standby");
    xfer(12'h000, 12);
    chk(st, 12'hB00, "oc cleared");
  endtask

  // Open load counted at standstill, boundary at 14 ticks
  task t_ol;
    xfer(12'hD0B, 12);
    pulse(osc, 15);
    xfer(12'h00B, 12);
    chk(st, 12'hB0C, "open load");
    chk({a1, a2}, 12'h000, "zero code slow decay");
    xfer(12'h00B, 12);
    chk(st, 12'hB08, "zero code no flag");
    pulse(offb, 1);
    pulse(osc, 14);
    xfer(12'h00B, 12);
    chk(st, 12'hB00, "14 ticks");
    pulse(osc, 1);
    xfer(12'h00B, 12);
    chk(st, 12'hB08, "15 ticks");
  endtask

  // Reference select, shutdown, supply low, non-serial mode
  task t_power;
    analog_ref_select_n = 1'b0;
    wclk(8);
    chk(ext_ref, 12'h001, "ext ref");
    analog_ref_select_n = 1'b1;
    active_low_enable = 1'b1;
    wclk(8);
    chk({ref_on, pwr, osc_en}, 12'h000, "shutdown");
    xfer(12'hD0B, 12);
    chk(outs(), 12'h000, "cleared, ignored");
    active_low_enable = 1'b0;
    wclk(8);
    xfer(12'hD0B, 12);
    vlow = 1'b1;
    wclk(8);
    chk({pwr, osc_en}, 12'h000, "supply low");
    vlow = 1'b0;
    ser = 1'b0;
    xfer(12'h000, 12);
    chk(outs(), 12'hD0B, "non-serial ignored");
    active_low_enable = 1'b1;
    wclk(8);
    chk({ref_on, pwr}, 12'h002, "pin standby");
  endtask

  task results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reset for 10 cycles, then the scenarios
  initial begin
    {clk, active_low_enable, vlow, ot, pw, uv, low_side_overcurrent_a, offb, osc, fs, pwm} = '0;
    {rst, ser, analog_ref_select_n} = 3'b111;
    load = 3'h0;
    n_fail = 0;
    checks = 0;
    wclk(10);
    rst = 1'b0;
    wclk(4);
    t_cmd();
    t_fault();
    t_oc();
    t_ol();
    t_power();
    results();
  end

  // Hang guard, well beyond the expected run
  initial begin
    #500000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire

// file: verilog/scc_core.sv
/*
  Digital core of a two-coil microstep driver: serial command and
  status words, power states, open-load and overcurrent flags.
  Assumes all pin and analog-side inputs are asynchronous to I_CLK and
  that serial clock edges are far slower than I_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_core
  import scc_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic              I_SPI_SCK,
  input  wire logic              I_SPI_SDI,
  input  wire logic              I_SPI_CS_N,
  input  wire logic              I_ACTIVE_LOW_ENABLE_N,
  input  wire logic              I_SERIAL_MODE_SELECT,
  input  wire logic              I_ANALOG_REF_SELECT_N,
  input  wire logic              I_LOGIC_SUPPLY_LOW,
  input  wire logic              I_OVERTEMP,
  input  wire logic              I_TEMP_PREWARN,
  input  wire logic              I_SUPPLY_LOW,
  input  wire logic              I_OC_LOW_A,
  input  wire logic              I_OC_LOW_B,
  input  wire logic              I_OC_HIGH,
  input  wire logic              I_PWM_TICK,
  input  wire logic              I_PWM_OFF_A,
  input  wire logic              I_PWM_OFF_B,
  input  wire logic              I_OSC_TICK,
  input  wire logic              I_FULLSTEP,
  input  wire logic [LOAD_W-1:0] I_LOAD_INDICATOR,
  output logic                   O_SPI_SDO,
  output logic                   O_SPI_SDO_OE,
  output logic [CODE_W-1:0]      O_COIL_A_CURRENT_CODE,
  output logic [CODE_W-1:0]      O_COIL_B_CURRENT_CODE,
  output logic                   O_MIXED_DECAY_A,
  output logic                   O_MIXED_DECAY_B,
  output logic                   O_BRIDGE_A_POLARITY,
  output logic                   O_BRIDGE_B_POLARITY,
  output logic                   O_COIL_A_OUT_1,
  output logic                   O_COIL_A_OUT_2,
  output logic                   O_COIL_B_OUT_1,
  output logic                   O_COIL_B_OUT_2,
  output logic                   O_POWER_EN,
  output logic                   O_OSC_EN,
  output logic                   O_REF_ON,
  output logic                   O_EXT_REF
);
  import scc_pkg::*;

  // Core state, apart from the overcurrent guards, in one register
  typedef struct packed {
    logic [SI_W-1:0]      s1;        // Synchroniser first stage
    logic [SI_W-1:0]      s2;        // Synchroniser second stage
    logic [SI_W-1:0]      s3;        // Delayed copy for edges
    logic [11:0]          rx;        // Incoming command shifter
    logic [11:0]          tx;        // Outgoing status shifter
    logic [11:0]          cmd;       // Applied command word
    logic [3:0]           bits;      // Serial clock edges in frame
    logic [3:0]           olc_a;     // Oscillator cycles without switch-off
    logic [3:0]           olc_b;
    logic [LOAD_W-1:0]    load;      // Latched load indicator
    logic                 ol_a;      // Open-load flags
    logic                 ol_b;
    logic                 sdo;
    logic                 sdo_oe;
    logic                 pwr_en;
    logic                 osc_en;
    logic                 ref_on;
    logic                 ext_ref;
    logic                 a1;        // High-side selects per output
    logic                 a2;
    logic                 b1;
    logic                 b2;
    scc_pwr_e             pwr;       // Power state
  } scc_core_s;

  scc_core_s              q;
  scc_core_s              d;
  logic [SI_W-1:0]        async_in;  // Raw pin lanes
  logic [SI_W-1:0]        rise_v;    // Rising edges after sync
  logic [SI_W-1:0]        fall_v;    // Falling edges after sync
  logic [OC_N-1:0]        oc_flag;   // A low, B low, high side
  logic [OC_N-1:0]        oc_block;
  logic [WORD_BITS-1:0]   status;    // Word to shift out
  logic                   serial;
  logic                   disable_in;
  logic                   spi_rst;
  logic                   apply;
  logic                   rx_zero;
  logic                   oc_clr;
  logic                   fault;
  logic [CODE_W-1:0]      code_a;
  logic [CODE_W-1:0]      code_b;

  assign async_in = {I_LOAD_INDICATOR, I_FULLSTEP, I_OSC_TICK, I_PWM_OFF_B, I_PWM_OFF_A,
                     I_PWM_TICK, I_OC_HIGH, I_OC_LOW_B, I_OC_LOW_A, I_SUPPLY_LOW, I_TEMP_PREWARN,
                     I_OVERTEMP, I_LOGIC_SUPPLY_LOW, I_ANALOG_REF_SELECT_N, I_SERIAL_MODE_SELECT,
                     I_ACTIVE_LOW_ENABLE_N, I_SPI_CS_N, I_SPI_SDI, I_SPI_SCK};

  // Edges only from the second stage onward
  assign rise_v = q.s2 & ~q.s3;
  assign fall_v = ~q.s2 & q.s3;

  assign serial     = q.s2[SI_SER];
  assign disable_in = q.s2[SI_ENN];
  // Shutdown or non-serial mode holds the serial logic idle
  assign spi_rst    = !serial || q.pwr == PWR_SHUTDOWN;
  assign apply      = !spi_rst && rise_v[SI_CSN] && q.bits == BITS_FULL;
  assign rx_zero    = q.rx[CMD_CA_MSB -: CODE_W] == CODE_OFF && q.rx[CMD_CB_MSB -: CODE_W] == CODE_OFF;
  // Disable, or an applied word with both current codes zero, clears the overcurrent flags
  assign oc_clr     = disable_in || (apply && rx_zero);
  assign fault      = (|oc_flag) || q.s2[SI_UV] || q.s2[SI_OT];
  assign code_a     = q.cmd[CMD_CA_MSB -: CODE_W];
  assign code_b     = q.cmd[CMD_CB_MSB -: CODE_W];

  // One error counter per comparator
  genvar g;
  for (g = 0; g < OC_N; g++) begin : g_oc
    scc_oc_guard u_guard (
      .i_clk      (I_CLK),
      .i_rst      (I_SYS_RST),
      .i_clear    (oc_clr),
      .i_pwm_tick (rise_v[SI_PWM]),
      .i_oc       (rise_v[SI_OCA + g]),
      .o_flag     (oc_flag[g]),
      .o_block    (oc_block[g])
    );
  end

  // Status word assembly
  always_comb begin
    status                          = '0;
    status[ST_LD_MSB -: LOAD_W]     = q.load;
    status[ST_ONE]                  = 1'b1;
    status[ST_OT]                   = q.s2[SI_OT];
    status[ST_TEMP_PREWARN_FLAG]                 = q.s2[SI_TEMP_PREWARN_FLAG];
    status[ST_UV]                   = q.s2[SI_UV];
    status[ST_HIGH_SIDE_OVERCURRENT]                 = oc_flag[2];
    status[ST_OLB]                  = q.ol_b;
    status[ST_OLA]                  = q.ol_a;
    status[ST_OCB]                  = oc_flag[1];
    status[ST_OCA]                  = oc_flag[0];
  end

  // Oscillator cycles since the last PWM switch-off, saturating above the limit
  function automatic logic [3:0] ol_step(input logic [3:0] c, input logic on, off, tick);
    ol_step = c;
    if (!on || off) begin
      ol_step = '0;
    end else if (tick && c <= OL_OSC_LIMIT) begin
      ol_step = c + 4'h1;
    end
  endfunction

  // Next-state logic for the whole core
  always_comb begin
    d    = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;

    // Serial shifter: sample on rising, shift on falling clock edge
    if (spi_rst) begin
      d.rx     = '0;
      d.bits   = '0;
      d.sdo    = 1'b0;
      d.sdo_oe = 1'b0;
    end else if (fall_v[SI_CSN]) begin
      d.tx     = status;
      d.sdo    = status[WORD_BITS-1];
      d.bits   = '0;
      d.sdo_oe = 1'b1;
    end else if (rise_v[SI_CSN]) begin
      d.sdo_oe = 1'b0;
    end else if (!q.s2[SI_CSN]) begin
      if (rise_v[SI_SCK]) begin
        d.rx = {q.rx[WORD_BITS-2:0], q.s2[SI_SDI]};
        if (q.bits != 4'hF) begin
          d.bits = q.bits + 4'h1;
        end
      end else if (fall_v[SI_SCK]) begin
        d.tx  = {q.tx[WORD_BITS-2:0], 1'b0};
        d.sdo = q.tx[WORD_BITS-2];
      end
    end

    // Command register; a short or long frame is dropped
    if (disable_in) begin
      d.cmd = CMD_RESET;
    end else if (apply) begin
      d.cmd = q.rx;
    end

    // Load indicator, once per full step
    if (disable_in) begin
      d.load = '0;
    end else if (rise_v[SI_FS]) begin
      d.load = q.s2[SI_LD +: LOAD_W];
    end

    // Open-load detection, off while the code is zero
    d.olc_a = ol_step(q.olc_a, code_a != CODE_OFF, rise_v[SI_OFFA], rise_v[SI_OSC]);
    d.olc_b = ol_step(q.olc_b, code_b != CODE_OFF, rise_v[SI_OFFB], rise_v[SI_OSC]);
    d.ol_a  = code_a != CODE_OFF && (q.olc_a > OL_OSC_LIMIT || fault);
    d.ol_b  = code_b != CODE_OFF && (q.olc_b > OL_OSC_LIMIT || fault);

    // Power state machine; outputs drop one state before the oscillator
    case (q.pwr)
      PWR_RUN: begin
        if ((serial && disable_in) || stby_req(q)) begin
          d.pwr = PWR_OUT_OFF;
        end
      end
      PWR_OUT_OFF: begin
        d.pwr = (serial && disable_in) ? PWR_SHUTDOWN : PWR_STANDBY;
      end
      PWR_STANDBY: begin
        if (serial && disable_in) begin
          d.pwr = PWR_SHUTDOWN;
        end else if (!stby_req(q)) begin
          d.pwr = PWR_RUN;
        end
      end
      default: begin
        if (!(serial && disable_in)) begin
          d.pwr = PWR_STANDBY;
        end
      end
    endcase

    // Output stage; a zero code leaves both high sides off: slow decay
    d.pwr_en  = d.pwr == PWR_RUN && !q.s2[SI_OT];
    d.osc_en  = d.pwr == PWR_RUN || d.pwr == PWR_OUT_OFF;
    d.ref_on  = d.pwr != PWR_SHUTDOWN;
    d.ext_ref = serial && !q.s2[SI_ANN];
    d.a1 = d.pwr_en && code_a != CODE_OFF && !oc_block[0] && !oc_block[2] && !q.cmd[CMD_PHA];
    d.a2 = d.pwr_en && code_a != CODE_OFF && !oc_block[0] && !oc_block[2] && q.cmd[CMD_PHA];
    d.b1 = d.pwr_en && code_b != CODE_OFF && !oc_block[1] && !oc_block[2] && !q.cmd[CMD_PHB];
    d.b2 = d.pwr_en && code_b != CODE_OFF && !oc_block[1] && !oc_block[2] && q.cmd[CMD_PHB];
  end

  // Standby request: logic supply low, command, or pin outside serial mode
  function automatic logic stby_req(input scc_core_s s);
    stby_req = s.s2[SI_VCCL] || (s.s2[SI_SER] ? (s.cmd[CMD_CA_MSB -: CODE_W] == CODE_OFF &&
               s.cmd[CMD_CB_MSB -: CODE_W] == CODE_OFF) : s.s2[SI_ENN]);
  endfunction

  // State register, synchronous reset
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs, all straight from the state register
  assign O_SPI_SDO             = q.sdo;
  assign O_SPI_SDO_OE          = q.sdo_oe;
  assign O_COIL_A_CURRENT_CODE = q.cmd[CMD_CA_MSB -: CODE_W];
  assign O_COIL_B_CURRENT_CODE = q.cmd[CMD_CB_MSB -: CODE_W];
  assign O_MIXED_DECAY_A       = q.cmd[CMD_MDA];
  assign O_MIXED_DECAY_B       = q.cmd[CMD_MDB];
  assign O_BRIDGE_A_POLARITY   = q.cmd[CMD_PHA];
  assign O_BRIDGE_B_POLARITY   = q.cmd[CMD_PHB];
  assign O_COIL_A_OUT_1        = q.a1;
  assign O_COIL_A_OUT_2        = q.a2;
  assign O_COIL_B_OUT_1        = q.b1;
  assign O_COIL_B_OUT_2        = q.b2;
  assign O_POWER_EN            = q.pwr_en;
  assign O_OSC_EN              = q.osc_en;
  assign O_REF_ON              = q.ref_on;
  assign O_EXT_REF             = q.ext_ref;

  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  property p_apply;
    apply |=> q.cmd == $past(q.rx) || $past(disable_in);
  endproperty
  a_apply: assert property (p_apply) else $error("word not applied");

  property p_status_load;
    (!spi_rst && fall_v[SI_CSN]) |=> q.tx[ST_ONE] && q.sdo == $past(status[WORD_BITS-1]);
  endproperty
  a_status_load: assert property (p_status_load) else $error("status not loaded");

  property p_disable_clear;
    disable_in |=> q.cmd == CMD_RESET;
  endproperty
  a_disable_clear: assert property (p_disable_clear) else $error("command not cleared");

  property p_ol_zero;
    code_a == CODE_OFF |=> !q.ol_a;
  endproperty
  a_ol_zero: assert property (p_ol_zero) else $error("open load with zero code");

  property p_ol_fault;
    (code_b != CODE_OFF && q.s2[SI_UV]) |=> q.ol_b;
  endproperty
  a_ol_fault: assert property (p_ol_fault) else $error("fault not on open load");

  property p_out_first;
    q.pwr == PWR_OUT_OFF |-> !O_POWER_EN && O_OSC_EN ##1 !O_OSC_EN;
  endproperty
  a_out_first: assert property (p_out_first) else $error("standby order broken");

  property p_vcc_low;
    q.s2[SI_VCCL] |=> !O_POWER_EN;
  endproperty
  a_vcc_low: assert property (p_vcc_low) else $error("no standby on supply low");

  property p_shutdown;
    (serial && disable_in) [*3] |-> q.pwr == PWR_SHUTDOWN && !O_SPI_SDO_OE;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not entered");

  property p_load;
    rise_v[SI_FS] && !disable_in |=> q.load == $past(q.s2[SI_LD +: LOAD_W]);
  endproperty
  a_load: assert property (p_load) else $error("load not latched");
endmodule
`default_nettype wire

// file: verilog/scc_oc_guard.sv
/*
  One overcurrent error counter per comparator: counts overcurrent
  events, trips a flag and holds the bridge off.
  Assumes single-cycle event pulses on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_oc_guard
  import scc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_clear,
  input  wire logic i_pwm_tick,
  input  wire logic i_oc,
  output logic      o_flag,
  output logic      o_block
);
  typedef struct packed {
    logic [1:0] err;    // Overcurrent events seen
    logic [6:0] quiet;  // PWM cycles without overcurrent
    logic [5:0] hold;   // Remaining forced-off cycles
    logic       flag;   // Tripped flag
  } scc_oc_s;
  scc_oc_s q, d;

  // Next state; clear first so a new trip wins
  always_comb begin
    d = q;
    if (i_clear) begin
      d = '0;
    end
    if (i_pwm_tick && q.hold != 6'h00) begin
      d.hold = q.hold - 6'h01;
    end
    if (i_oc) begin
      d.quiet = '0;
      if (q.err + 2'h1 == OC_TRIP) begin
        d.err  = '0;
        d.flag = 1'b1;
        d.hold = OC_WINDOW;
      end else begin
        d.err = q.err + 2'h1;
      end
    end else if (i_pwm_tick && !i_clear) begin
      // More than 64 quiet cycles forgets old events
      if (q.quiet > {1'b0, OC_WINDOW}) begin
        d.err = '0;
      end else begin
        d.quiet = q.quiet + 7'h01;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_flag  = q.flag;
  assign o_block = q.hold != 6'h00;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_trip_hold;
    $rose(q.flag) |-> q.hold == OC_WINDOW;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip without hold");

  property p_third_event;
    (i_oc && q.err == 2'h2) |=> q.flag;
  endproperty
  a_third_event: assert property (p_third_event) else $error("third event missed");
endmodule
`default_nettype wire

// file: verilog/scc_pkg.sv
/*
  Shared constants for the stepper coil control core: command and
  status bit layout, counter limits, synchroniser lane map, power states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scc_pkg;
  localparam int WORD_BITS   = 12;  // Serial word length
  localparam int CODE_W      = 4;   // Coil current code width
  localparam int LOAD_W      = 3;   // Load indicator width
  // Command word layout
  localparam int CMD_MDA     = 11;
  localparam int CMD_CA_MSB  = 10;
  localparam int CMD_PHA     = 6;
  localparam int CMD_MDB     = 5;
  localparam int CMD_CB_MSB  = 4;
  localparam int CMD_PHB     = 0;
  // Status word layout
  localparam int ST_LD_MSB   = 11;
  localparam int ST_ONE      = 8;
  localparam int ST_OT       = 7;
  localparam int ST_TEMP_PREWARN_FLAG     = 6;
  localparam int ST_UV       = 5;
  localparam int ST_HIGH_SIDE_OVERCURRENT     = 4;
  localparam int ST_OLB      = 3;
  localparam int ST_OLA      = 2;
  localparam int ST_OCB      = 1;
  localparam int ST_OCA      = 0;
  // Reset values and limits
  localparam logic [11:0] CMD_RESET    = 12'h000;
  localparam logic [3:0]  CODE_OFF     = 4'h0;
  localparam logic [3:0]  BITS_FULL    = 4'hC;   // Twelve clock edges
  localparam logic [3:0]  OL_OSC_LIMIT = 4'hE;   // 14 oscillator cycles
  localparam logic [1:0]  OC_TRIP      = 2'h3;   // Events to trip
  localparam logic [5:0]  OC_WINDOW    = 6'h3F;  // 63 PWM cycles
  // Synchroniser lanes
  localparam int SI_SCK  = 0;
  localparam int SI_SDI  = 1;
  localparam int SI_CSN  = 2;
  localparam int SI_ENN  = 3;
  localparam int SI_SER  = 4;
  localparam int SI_ANN  = 5;
  localparam int SI_VCCL = 6;
  localparam int SI_OT   = 7;
  localparam int SI_TEMP_PREWARN_FLAG = 8;
  localparam int SI_UV   = 9;
  localparam int SI_OCA  = 10;  // LOW_SIDE_OVERCURRENT_A, LOW_SIDE_OVERCURRENT_B, HIGH_SIDE_OVERCURRENT are adjacent
  localparam int SI_PWM  = 13;
  localparam int SI_OFFA = 14;
  localparam int SI_OFFB = 15;
  localparam int SI_OSC  = 16;
  localparam int SI_FS   = 17;
  localparam int SI_LD   = 18;
  localparam int SI_W    = 21;
  localparam int OC_N    = 3;
  // Power states, reset value first
  typedef enum logic [1:0] {PWR_STANDBY, PWR_RUN, PWR_OUT_OFF, PWR_SHUTDOWN} scc_pwr_e;
endpackage
